// ==== src/ir_carrier_modulator_pkg.sv ====
// package: register map, field positions and reset values for the ir carrier modulator
package ir_carrier_modulator_pkg;
  // ==========================================================================
  // register byte addresses (apb, one aligned word each)
  localparam logic [7:0] ADDR_PRIMARY_HIGH = 8'h00;
  localparam logic [7:0] ADDR_PRIMARY_LOW = 8'h04;
  localparam logic [7:0] ADDR_SECONDARY_HIGH = 8'h08;
  localparam logic [7:0] ADDR_SECONDARY_LOW = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MARK_BUFFER = 8'h14;
  localparam logic [7:0] ADDR_SPACE_BUFFER = 8'h18;
  // ==========================================================================
  // field positions
  localparam int LATCH_BIT = 7;
  localparam int CS_ENABLE_BIT = 0;
  localparam int CS_IRQ_ENABLE_BIT = 1;
  localparam int CS_MODE_BIT = 2;
  localparam int CS_BASEBAND_BIT = 3;
  localparam int CS_EXT_SPACE_BIT = 4;
  localparam int CS_HALF_RATE_BIT = 6;
  localparam int CS_END_OF_CYCLE_BIT = 7;
  // ==========================================================================
  // reset values and counts
  localparam logic [5:0] COUNT_RESET = 6'h01;
  localparam logic [11:0] PERIOD_RESET = 12'h000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int OSC_PER_MOD_TICK = 8;
  localparam logic [2:0] MOD_TICK_LAST = 3'h7;
endpackage : ir_carrier_modulator_pkg

// ==== src/ir_carrier_modulator.sv ====
// ir carrier generator and mark/space modulator with apb register slave
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module ir_carrier_modulator
  import ir_carrier_modulator_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic infrared_output_pin_out,
  output logic cycle_irq_out
);
  // ==========================================================================
  // apb decode
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  assign access = psel_in && penable_in;
  assign wr = access && pwrite_in;
  assign rd = access && !pwrite_in;
  always_comb begin
    unique case (paddr_in)
      ADDR_PRIMARY_HIGH, ADDR_PRIMARY_LOW, ADDR_SECONDARY_HIGH, ADDR_SECONDARY_LOW,
      ADDR_CONTROL_STATUS, ADDR_MARK_BUFFER, ADDR_SPACE_BUFFER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================================
  // registers
  // primary and secondary count pairs
  logic [5:0] prim_high_q, prim_high_d, prim_low_q, prim_low_d;
  logic [5:0] sec_high_q, sec_high_d, sec_low_q, sec_low_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [11:0] mark_buf_q, mark_buf_d, space_buf_q, space_buf_d;
  logic latch_q, latch_d;
  logic latch_pend_q, latch_pend_d;
  logic latch_val_q, latch_val_d;
  logic eoc_q, eoc_d;
  logic status_read_q, status_read_d;
  logic eoc_event;
  logic enable;
  logic baseband_select;
  logic fsk;
  logic half;
  assign enable = ctrl_q[CS_ENABLE_BIT];
  assign baseband_select = ctrl_q[CS_BASEBAND_BIT];
  assign fsk = ctrl_q[CS_MODE_BIT];
  assign half = ctrl_q[CS_HALF_RATE_BIT];

  always_comb begin
    prim_high_d = prim_high_q;
    prim_low_d = prim_low_q;
    sec_high_d = sec_high_q;
    sec_low_d = sec_low_q;
    ctrl_d = ctrl_q;
    mark_buf_d = mark_buf_q;
    space_buf_d = space_buf_q;
    latch_d = latch_q;
    latch_pend_d = 1'b0;
    latch_val_d = latch_val_q;
    eoc_d = eoc_q;
    status_read_d = status_read_q;
    // the low-register write lands one oscillator period after the high one
    if (latch_pend_q) begin
      latch_d = latch_val_q;
    end
    if (wr) begin
      unique case (paddr_in)
        ADDR_PRIMARY_HIGH: begin
          prim_high_d = pwdata_in[5:0];
          latch_d = pwdata_in[LATCH_BIT];
        end
        ADDR_PRIMARY_LOW: begin
          prim_low_d = pwdata_in[5:0];
          latch_pend_d = 1'b1;
          latch_val_d = pwdata_in[LATCH_BIT];
        end
        ADDR_SECONDARY_HIGH: sec_high_d = pwdata_in[5:0];
        ADDR_SECONDARY_LOW: sec_low_d = pwdata_in[5:0];
        ADDR_CONTROL_STATUS: ctrl_d = {1'b0, pwdata_in[6:0]};
        ADDR_MARK_BUFFER: mark_buf_d = pwdata_in[11:0];
        ADDR_SPACE_BUFFER: space_buf_d = pwdata_in[11:0];
        default: ;
      endcase
    end
    // status read arms the clear; a buffer access then clears the flag
    if (rd && paddr_in == ADDR_CONTROL_STATUS) begin
      status_read_d = 1'b1;
    end
    if (access && (paddr_in == ADDR_MARK_BUFFER || paddr_in == ADDR_SPACE_BUFFER) && status_read_q) begin
      eoc_d = 1'b0;
      status_read_d = 1'b0;
    end
    if (eoc_event) begin
      eoc_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prim_high_q <= COUNT_RESET;
      prim_low_q <= COUNT_RESET;
      sec_high_q <= COUNT_RESET;
      sec_low_q <= COUNT_RESET;
      ctrl_q <= CONTROL_RESET;
      mark_buf_q <= PERIOD_RESET;
      space_buf_q <= PERIOD_RESET;
      latch_q <= 1'b0;
      latch_pend_q <= 1'b0;
      latch_val_q <= 1'b0;
      eoc_q <= 1'b0;
      status_read_q <= 1'b0;
    end else begin
      prim_high_q <= prim_high_d;
      prim_low_q <= prim_low_d;
      sec_high_q <= sec_high_d;
      sec_low_q <= sec_low_d;
      ctrl_q <= ctrl_d;
      mark_buf_q <= mark_buf_d;
      space_buf_q <= space_buf_d;
      latch_q <= latch_d;
      latch_pend_q <= latch_pend_d;
      latch_val_q <= latch_val_d;
      eoc_q <= eoc_d;
      status_read_q <= status_read_d;
    end
  end

  // ==========================================================================
  // modulator/carrier engine
  logic running_q, running_d;
  logic half_ph_q, half_ph_d;
  logic [5:0] car_cnt_q, car_cnt_d;
  logic car_out_q, car_out_d;
  logic sec_sel_q, sec_sel_d;
  logic [2:0] div8_q, div8_d;
  logic [11:0] mod_cnt_q, mod_cnt_d;
  logic [11:0] space_reg_q, space_reg_d;
  logic in_space_q, in_space_d;
  logic ext_q, ext_d;
  logic gate_q, gate_d;
  logic tick;
  logic [5:0] cmp_val;
  logic car_period_end;
  logic mod_tick;
  logic [11:0] cnt_dec;

  assign tick = running_q && (!half || half_ph_q);
  assign cmp_val = car_out_q ? ((fsk && sec_sel_q) ? sec_high_q : prim_high_q)
                             : ((fsk && sec_sel_q) ? sec_low_q : prim_low_q);
  assign car_period_end = tick && !baseband_select && !car_out_q && (car_cnt_q + 6'h01 == cmp_val);
  assign cnt_dec = mod_cnt_q - 12'h001;
  assign mod_tick = fsk ? car_period_end : (tick && div8_q == MOD_TICK_LAST);
  // match of complemented counter ends the cycle
  assign eoc_event = mod_tick && in_space_q && (~cnt_dec == space_reg_q);

  always_comb begin
    running_d = running_q;
    half_ph_d = running_q ? !half_ph_q : 1'b0;
    car_cnt_d = car_cnt_q;
    car_out_d = car_out_q;
    sec_sel_d = sec_sel_q;
    div8_d = div8_q;
    mod_cnt_d = mod_cnt_q;
    space_reg_d = space_reg_q;
    in_space_d = in_space_q;
    ext_d = ext_q;
    gate_d = gate_q;
    if (!running_q) begin
      // enabling initialises everything; mark starts with carrier high
      // clocks start on enable
      if (enable) begin
        running_d = 1'b1;
        car_cnt_d = 6'h00;
        car_out_d = 1'b1;
        sec_sel_d = 1'b0;
        div8_d = 3'h0;
        mod_cnt_d = mark_buf_q;
        space_reg_d = space_buf_q;
        in_space_d = ctrl_q[CS_EXT_SPACE_BIT];
        ext_d = ctrl_q[CS_EXT_SPACE_BIT];
        gate_d = !ctrl_q[CS_EXT_SPACE_BIT];
      end
    end else begin
      if (tick) begin
        div8_d = div8_q + 3'h1;
        if (baseband_select) begin
          car_out_d = 1'b1;
          car_cnt_d = 6'h00;
        end else if (car_cnt_q + 6'h01 == cmp_val) begin
          car_cnt_d = 6'h00;
          car_out_d = !car_out_q;
        end else begin
          car_cnt_d = car_cnt_q + 6'h01;
        end
      end
      if (mod_tick) begin
        // count down through mark and space
        mod_cnt_d = cnt_dec;
        if (!in_space_q && mod_cnt_q == 12'h000) begin
          in_space_d = 1'b1;
          if (fsk && !ext_q) begin
            sec_sel_d = !sec_sel_q;
          end
          if (space_reg_q == 12'h000) begin
            in_space_d = 1'b0;
          end
        end
        if (eoc_event || (!in_space_q && mod_cnt_q == 12'h000 && space_reg_q == 12'h000)) begin
          mod_cnt_d = mark_buf_q;
          space_reg_d = space_buf_q;
          ext_d = ctrl_q[CS_EXT_SPACE_BIT];
          in_space_d = ctrl_q[CS_EXT_SPACE_BIT];
          if (!enable) begin
            running_d = 1'b0;
          end
        end
      end
      // gate opens with mark, closes only while carrier low, or at once in baseband
      if (!in_space_d && !ext_d) begin
        gate_d = 1'b1;
      end else if (!car_out_d || baseband_select) begin
        gate_d = 1'b0;
      end
      // carrier restarts as the gate opens, so no partial first pulse
      if (!gate_q && gate_d) begin
        car_cnt_d = 6'h00;
        car_out_d = 1'b1;
      end
      // zero space keeps the gate open across the pair switch
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      running_q <= 1'b0;
      half_ph_q <= 1'b0;
      car_cnt_q <= 6'h00;
      car_out_q <= 1'b0;
      sec_sel_q <= 1'b0;
      div8_q <= 3'h0;
      mod_cnt_q <= PERIOD_RESET;
      space_reg_q <= PERIOD_RESET;
      in_space_q <= 1'b0;
      ext_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      running_q <= running_d;
      half_ph_q <= half_ph_d;
      car_cnt_q <= car_cnt_d;
      car_out_q <= car_out_d;
      sec_sel_q <= sec_sel_d;
      div8_q <= div8_d;
      mod_cnt_q <= mod_cnt_d;
      space_reg_q <= space_reg_d;
      in_space_q <= in_space_d;
      ext_q <= ext_d;
      gate_q <= gate_d;
    end
  end

  // ==========================================================================
  // outputs
  logic pin_d;
  logic [31:0] rdata_d;
  always_comb begin
    if (!running_q) begin
      pin_d = latch_q;
    end else begin
      pin_d = gate_q && (car_out_q || baseband_select);
    end
    rdata_d = 32'h0000_0000;
    unique case (paddr_in)
      ADDR_PRIMARY_HIGH: rdata_d = {24'h000000, latch_q, 1'b0, prim_high_q};
      ADDR_PRIMARY_LOW: rdata_d = {24'h000000, latch_q, 1'b0, prim_low_q};
      ADDR_SECONDARY_HIGH: rdata_d = {26'h0000000, sec_high_q};
      ADDR_SECONDARY_LOW: rdata_d = {26'h0000000, sec_low_q};
      ADDR_CONTROL_STATUS: rdata_d = {24'h000000, eoc_q, ctrl_q[6:0]};
      ADDR_MARK_BUFFER: rdata_d = {20'h00000, mark_buf_q};
      ADDR_SPACE_BUFFER: rdata_d = {20'h00000, space_buf_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      infrared_output_pin_out <= 1'b0;
      cycle_irq_out <= 1'b0;
    end else begin
      // no wait state: pready registered from setup
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out <= rdata_d;
      infrared_output_pin_out <= pin_d;
      cycle_irq_out <= eoc_d && ctrl_d[CS_IRQ_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // checks
  property p_idle_pin;
    @(posedge clock_in) disable iff (!arst_n_in) !running_q |=> infrared_output_pin_out == $past(latch_q);
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("idle pin not latch");
  property p_latch_delay;
    @(posedge clock_in) disable iff (!arst_n_in) latch_pend_q |=> latch_q == $past(latch_val_q);
  endproperty
  a_latch_delay: assert property (p_latch_delay) else $error("delayed latch write lost");
  property p_count_range;
    @(posedge clock_in) disable iff (!arst_n_in) car_period_end |=> car_cnt_q == 6'h00 && car_out_q;
  endproperty
  a_count_range: assert property (p_count_range) else $error("carrier not restarted");
  property p_baseband_select_high;
    @(posedge clock_in) disable iff (!arst_n_in) running_q && baseband_select && tick |=> car_out_q;
  endproperty
  a_baseband_select_high: assert property (p_baseband_select_high) else $error("baseband carrier low");
  property p_eoc_set;
    @(posedge clock_in) disable iff (!arst_n_in) eoc_event |=> eoc_q;
  endproperty
  a_eoc_set: assert property (p_eoc_set) else $error("cycle flag not set");
  property p_stop_low;
    @(posedge clock_in) disable iff (!arst_n_in) !running_q && !enable |=> !running_q && $stable(mod_cnt_q);
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("modulator counts while stopped");
  property p_gate_close;
    @(posedge clock_in) disable iff (!arst_n_in) $fell(gate_q) && !baseband_select |-> !car_out_q;
  endproperty
  a_gate_close: assert property (p_gate_close) else $error("gate closed on high carrier");
  property p_gate_restart;
    @(posedge clock_in) disable iff (!arst_n_in) $rose(gate_q) && !baseband_select |-> car_out_q && car_cnt_q == 6'h00;
  endproperty
  a_gate_restart: assert property (p_gate_restart) else $error("carrier not restarted at gate open");
  property p_div8;
    @(posedge clock_in) disable iff (!arst_n_in) running_q && !fsk && mod_tick |-> div8_q == MOD_TICK_LAST;
  endproperty
  a_div8: assert property (p_div8) else $error("modulator tick off divider");
endmodule : ir_carrier_modulator

// ==== tb/ir_led_model.sv ====
// infrared led driver model: measures pulse widths seen on the output pin
`timescale 1ns/1ps
module ir_led_model (
  input wire logic clock_in,
  input wire logic drive_in,
  input wire logic clear_in,
  output int rises_out,
  output int last_high_out,
  output int last_low_out,
  output logic [127:0] seen_high_out
);
  int run_q = 0;
  logic prev_q = 1'b0;
  // ==========
  // run lengths in clocks; widths above 127 only show in last_high_out
  always @(posedge clock_in) begin
    prev_q <= drive_in;
    if (clear_in) begin
      rises_out <= 0;
      seen_high_out <= '0;
      run_q <= 1;
    end else if (drive_in !== prev_q) begin
      run_q <= 1;
      if (drive_in === 1'b1) begin
        rises_out <= rises_out + 1;
        last_low_out <= run_q;
      end else begin
        last_high_out <= run_q;
        if (run_q < 128) seen_high_out[run_q] <= 1'b1;
      end
    end else begin
      run_q <= run_q + 1;
    end
  end
endmodule : ir_led_model

// ==== tb/ir_carrier_modulator_test.sv ====
// self-checking bench for the ir carrier modulator
`timescale 1ns/1ps
module ir_carrier_modulator_test;
  import ir_carrier_modulator_pkg::*;
  logic clock_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, clr = 1'b1;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, q;
  logic pready_out, pslverr_out, pin, irq, e;
  logic [127:0] seen;
  logic [5:0] hi, lo, h2, l2;
  logic [11:0] mk, sp;
  int rises, lh, ll, n_errors = 0, compares = 0, d1, d2, per;
  always #4 clock_in = ~clock_in;
  ir_carrier_modulator dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .infrared_output_pin_out(pin), .cycle_irq_out(irq));
  ir_led_model led (.clock_in(clock_in), .drive_in(pin), .clear_in(clr), .rises_out(rises),
    .last_high_out(lh), .last_low_out(ll), .seen_high_out(seen));
  // ==========
  // shared tasks
  task automatic check(input string nm, input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck transfer
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic lat(input logic [7:0] a, input logic [31:0] d, output int n);
    apb(1'b1, a, d);
    n = 0;
    while (pin !== d[LATCH_BIT] && n < 10) begin
      @(posedge clock_in);
      n++;
    end
  endtask : lat
  task automatic clear_led();
    clr <= 1'b1;
    @(posedge clock_in);
    clr <= 1'b0;
  endtask : clear_led
  task automatic wait_rises(input int k);
    int n;
    n = 0;
    while (rises < k && n < 20000) begin
      @(posedge clock_in);
      n++;
    end
    check("rise_wait", n < 20000, 1'b1);
  endtask : wait_rises
  // the first pulses after a mode change may be mixed, so they are discarded
  task automatic settle(input int k);
    clear_led();
    wait_rises(2);
    while (pin !== 1'b0) @(posedge clock_in);
    clear_led();
    wait_rises(k);
  endtask : settle
  task automatic final_report();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (90000) @(posedge clock_in);
    n_errors++;
    final_report();
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'hfc66));
    // non-zero counts loaded before any enable
    hi = 6'($urandom_range(20, 1));
    lo = 6'($urandom_range(20, 1));
    h2 = 6'($urandom_range(30, 21));
    l2 = 6'($urandom_range(30, 21));
    mk = 12'($urandom_range(40, 20));
    sp = 12'($urandom_range(40, 20));
    per = 8 * (int'(mk) + int'(sp) + 1);
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'b1;
    apb(1'b0, ADDR_PRIMARY_HIGH, 32'h0);
    check("latch_reset", q[LATCH_BIT], 1'b0);
    apb(1'b0, ADDR_CONTROL_STATUS, 32'h0);
    check("ctrl_reset", q, {24'h0, CONTROL_RESET});
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped", {e, q}, 33'h100000000);
    apb(1'b1, ADDR_PRIMARY_HIGH, {24'h0, 2'b10, hi});
    apb(1'b0, ADDR_PRIMARY_LOW, 32'h0);
    check("low_latch", q, {24'h0, 2'b10, COUNT_RESET});
    apb(1'b1, ADDR_SECONDARY_HIGH, {26'h3ffffff, h2});
    apb(1'b1, ADDR_SECONDARY_LOW, {26'h3ffffff, l2});
    apb(1'b0, ADDR_SECONDARY_HIGH, 32'h0);
    check("sec_high", q, {26'h0, h2});
    apb(1'b0, ADDR_SECONDARY_LOW, 32'h0);
    check("sec_low", q, {26'h0, l2});
    // pin follows latch, low-register write one clock later
    lat(ADDR_PRIMARY_LOW, {24'h0, 2'b00, lo}, d1);
    lat(ADDR_PRIMARY_HIGH, {24'h0, 2'b10, hi}, d2);
    check("pin_latch", d2 < 10, 1'b1);
    check("latch_skew", d1 - d2, 1);
    lat(ADDR_PRIMARY_LOW, {24'h0, 2'b00, lo}, d1);
    apb(1'b0, ADDR_PRIMARY_HIGH, 32'h0);
    check("high_back", q, {24'h0, 2'b00, hi});
    apb(1'b1, ADDR_MARK_BUFFER, {20'h0, mk});
    apb(1'b1, ADDR_SPACE_BUFFER, {20'h0, sp});
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h01);
    settle(6);
    check("carrier_high", seen, 128'h1 << hi);
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h41);
    settle(6);
    check("half_carrier", seen, 128'h1 << (2 * hi));
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h09);
    settle(3);
    check("bb_mark", lh, (int'(mk) + 1) * 8);
    check("bb_space", ll, int'(sp) * 8);
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h49);
    settle(3);
    check("half_mark", lh, (int'(mk) + 1) * 16);
    check("half_space", ll, int'(sp) * 16);
    // fsk alternates pairs with no gap
    apb(1'b1, ADDR_SPACE_BUFFER, 32'h0);
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h05);
    settle(3 * (int'(mk) + 1));
    check("fsk_pairs", seen, (128'h1 << hi) | (128'h1 << h2));
    check("fsk_nogap", ll === int'(lo) || ll === int'(l2), 1'b1);
    apb(1'b1, ADDR_SPACE_BUFFER, {20'h0, sp});
    // extended space suppresses marks until cleared
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h19);
    repeat (2 * per) @(posedge clock_in);
    clear_led();
    repeat (3 * per) @(posedge clock_in);
    check("ext_space", rises, 0);
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h09);
    wait_rises(1);
    // end-of-cycle flag, irq raised, cleared and masked
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h0b);
    for (d1 = 0; d1 < 2 * per && irq !== 1'b1; d1++) @(posedge clock_in);
    check("irq_set", irq, 1'b1);
    // align to a fresh cycle start so no new cycle end lands inside the clear sequence
    clear_led();
    wait_rises(1);
    apb(1'b0, ADDR_CONTROL_STATUS, 32'h0);
    check("eoc_flag", q[CS_END_OF_CYCLE_BIT], 1'b1);
    apb(1'b0, ADDR_MARK_BUFFER, 32'h0);
    check("mark_back", q, {20'h0, mk});
    repeat (2) @(posedge clock_in);
    check("irq_clear", irq, 1'b0);
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h09);
    repeat (2 * per) @(posedge clock_in);
    check("irq_mask", irq, 1'b0);
    apb(1'b0, ADDR_CONTROL_STATUS, 32'h0);
    check("eoc_masked", q[CS_END_OF_CYCLE_BIT], 1'b1);
    // disable finishes the cycle, then holds the pin low
    apb(1'b1, ADDR_CONTROL_STATUS, 32'h0);
    repeat (2 * per) @(posedge clock_in);
    clear_led();
    repeat (2 * per) @(posedge clock_in);
    check("off_rises", rises, 0);
    check("off_pin", pin, 1'b0);
    final_report();
  end
endmodule : ir_carrier_modulator_test
